// ==== hdl/serial_fifo_threshold_status.v ====
// transmit/receive fifo control and status of a serial channel
// assumes byte pushes/pops from the shifters are single-cycle strobes
`timescale 1ns/10ps
`include "serial_fifo_consts.vh"
module serial_fifo_threshold_status (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // register port
  input  wire [3:0]  addr,
  input  wire [31:0] wrData,
  input  wire        wrStrobe,
  input  wire        rdStrobe,
  output reg  [31:0] rdData,
  // system state
  input  wire        idleEntry,
  // transmit shifter side
  output wire        txValid,
  output wire [7:0]  txByte,
  input  wire        txTake,
  // receive shifter side
  input  wire        rxPush,
  input  wire [7:0]  rxByte,
  // interrupt
  output wire        irq
);

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  reg        chanEn_r;
  reg        idleRun_r;
  reg        qEn_r;
  reg        fullDup_r;
  reg        txCond_r;
  reg [1:0]  txThr_r;
  reg [1:0]  irqStat_r;
  reg [1:0]  irqEn_r;
  reg        rxOvr_r;

  wire wrEn   = wrStrobe && addr == `ADDR_ENABLE;
  wire wrMode = wrStrobe && addr == `ADDR_MODE1;
  wire wrSet  = wrStrobe && addr == `ADDR_SETUP;
  wire wrCfg  = wrStrobe && addr == `ADDR_TX_CONFIG;
  wire wrBuf  = wrStrobe && addr == `ADDR_DATA_BUF;
  wire rdBuf  = rdStrobe && addr == `ADDR_DATA_BUF;
  wire txClr  = wrCfg && wrData[`TXCFG_CLEAR_BIT];
  // config falls back when the channel stops or idles without run
  wire cfgDrop = !chanEn_r || (idleEntry && !idleRun_r);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      chanEn_r  <= 1'b0;
      idleRun_r <= 1'b0;
      qEn_r     <= 1'b0;
      fullDup_r <= 1'b0;
    end else begin
      if (wrEn)
        chanEn_r <= wrData[0];
      if (wrMode)
        idleRun_r <= wrData[0];
      if (wrSet) begin
        qEn_r     <= wrData[`SETUP_EN_BIT];
        fullDup_r <= wrData[`SETUP_FULL_BIT];
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      txCond_r <= 1'b0;
      txThr_r  <= 2'h0;
    end else if (cfgDrop) begin
      txCond_r <= 1'b0;
      txThr_r  <= 2'h0;
    end else if (wrCfg) begin
      txCond_r <= wrData[`TXCFG_COND_BIT];
      txThr_r  <= wrData[1:0];
    end
  end

  // ------------------------------------------------------------
  // fifo storage
  // ------------------------------------------------------------
  // one four-byte array; full duplex splits it in two halves
  wire [2:0] depth = fullDup_r ? `DEPTH_FULL : `DEPTH_HALF;
  reg  [7:0] mem_r [0:3];
  reg  [1:0] txWp_r;
  reg  [1:0] txRp_r;
  reg  [2:0] txLvl_r;
  reg  [1:0] rxWp_r;
  reg  [1:0] rxRp_r;
  reg  [2:0] rxLvl_r;

  // half duplex uses the whole array for both; the direction is
  // software's choice, so only one queue should be active then
  wire [1:0] base    = fullDup_r ? 2'h2 : 2'h0;
  wire [1:0] mask    = fullDup_r ? 2'h1 : 2'h3;
  wire       txPush  = wrBuf && qEn_r && txLvl_r < depth;
  wire       txPop   = txValid && txTake;
  wire       rxRoom  = rxLvl_r < depth;
  wire       rxStore = rxPush && qEn_r && rxRoom;
  wire       rxPop   = rdBuf && rxLvl_r != 3'h0;
  wire [1:0] txAddr  = txWp_r & mask;
  wire [1:0] rxAddr  = base + (rxWp_r & mask);

  assign txValid = qEn_r && txLvl_r != 3'h0;
  assign txByte  = mem_r[txRp_r & mask];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gStore
      always @(posedge clk or posedge reset) begin
        if (reset)
          mem_r[gi] <= 8'h00;
        else if (txPush && txAddr == gi)
          mem_r[gi] <= wrData[7:0];
        else if (rxStore && rxAddr == gi)
          mem_r[gi] <= rxByte;
      end
    end
  endgenerate

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      txWp_r  <= 2'h0;
      txRp_r  <= 2'h0;
      txLvl_r <= 3'h0;
    end else if (txClr) begin
      txWp_r  <= 2'h0;
      txRp_r  <= 2'h0;
      txLvl_r <= 3'h0;
    end else begin
      if (txPush)
        txWp_r <= (txWp_r + 2'h1) & mask;
      if (txPop)
        txRp_r <= (txRp_r + 2'h1) & mask;
      if (txPush && !txPop)
        txLvl_r <= txLvl_r + 3'h1;
      else if (txPop && !txPush)
        txLvl_r <= txLvl_r - 3'h1;
    end
  end

  // the receive queue has no clear here; its config lives elsewhere
  wire [1:0] rxRdAddr = base + (rxRp_r & mask);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rxWp_r   <= 2'h0;
      rxRp_r   <= 2'h0;
      rxLvl_r  <= 3'h0;
    end else begin
      if (rxStore)
        rxWp_r <= (rxWp_r + 2'h1) & mask;
      // the popped byte leaves through the read mux in the same cycle
      if (rxPop)
        rxRp_r <= (rxRp_r + 2'h1) & mask;
      if (rxStore && !rxPop)
        rxLvl_r <= rxLvl_r + 3'h1;
      else if (rxPop && !rxStore)
        rxLvl_r <= rxLvl_r - 3'h1;
    end
  end

  // ------------------------------------------------------------
  // overrun flag
  // ------------------------------------------------------------
  wire ovrEvent = rxPush && qEn_r && !rxRoom && !rxPop;

  always @(posedge clk or posedge reset) begin
    if (reset)
      rxOvr_r <= 1'b0;
    else if (ovrEvent)
      rxOvr_r <= 1'b1;
    else if (rdBuf)
      rxOvr_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // transmit threshold and interrupts
  // ------------------------------------------------------------
  // full duplex threshold only knows empty or one byte, so bit 1 is ignored
  wire [2:0] thrLvl = fullDup_r ? {2'h0, txThr_r[0]}
                                : {1'b0, txThr_r};
  wire txHit = txCond_r ? (txLvl_r <= thrLvl)
                        : (txLvl_r == thrLvl);
  reg  txHit_r;
  wire wrClrIrq = wrStrobe && addr == `ADDR_IRQ_CLEAR;
  wire wrEnIrq  = wrStrobe && addr == `ADDR_IRQ_ENABLE;
  wire [1:0] irqEvt = {ovrEvent, txHit && !txHit_r && qEn_r};

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      txHit_r   <= 1'b0;
      irqStat_r <= 2'h0;
      irqEn_r   <= 2'h0;
    end else begin
      txHit_r <= txHit;
      // a new event beats a clear in the same cycle
      irqStat_r <= irqEvt | (irqStat_r & ~(wrClrIrq ? wrData[1:0] : 2'h0));
      if (wrEnIrq)
        irqEn_r <= wrData[1:0];
    end
  end

  assign irq = |(irqStat_r & irqEn_r);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset)
      rdData <= 32'h0000_0000;
    else if (rdStrobe) begin
      case (addr)
        `ADDR_DATA_BUF:   rdData <= {24'h0, mem_r[rxRdAddr]};
        `ADDR_ENABLE:     rdData <= {31'h0, chanEn_r};
        `ADDR_MODE1:      rdData <= {31'h0, idleRun_r};
        `ADDR_SETUP:      rdData <= {30'h0, fullDup_r, qEn_r};
        // clear bit always reads back as zero
        `ADDR_TX_CONFIG:  rdData <= {24'h0, 1'b0, txCond_r,
                                     4'h0, txThr_r};
        `ADDR_RX_STATUS:  rdData <= {24'h0, rxOvr_r, 4'h0,
                                     rxLvl_r};
        `ADDR_TX_STATUS:  rdData <= {29'h0, txLvl_r};
        `ADDR_IRQ_STATUS: rdData <= {30'h0, irqStat_r};
        `ADDR_IRQ_ENABLE: rdData <= {30'h0, irqEn_r};
        default:          rdData <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== shared/serial_fifo_consts.vh ====
// constants of the serial channel fifo control and status block
// assumes a plain register port with 32-bit data and word indices
// Function
// - writing one to the transmit clear bit empties the transmit fifo, zeroes its level and resets the write pointer.
// - the transmit clear bit is write-only, writing zero does nothing and it always reads as zero.
// - the condition select bit chooses transmit interrupt on level equal to threshold (0) or level at or below it (1).
// - the transmit config register returns to reset whenever the channel is disabled or idle is entered with idle operation off.
// - the receive status register holds a read-only overrun flag at bit 7.
// - reading received data from the channel data buffer clears the overrun flag.
// - a three-bit read-only field reports the receive fill level from 000 to 100.
// - a three-bit read-only field reports the transmit fill level from 000 to 100.
// - full duplex gives two bytes to each fifo, half duplex gives four bytes to one direction.
`ifndef SERIAL_FIFO_CONSTS_VH
`define SERIAL_FIFO_CONSTS_VH
`define ADDR_DATA_BUF    4'h0
`define ADDR_ENABLE      4'h1
`define ADDR_MODE1       4'h2
`define ADDR_SETUP       4'h3
`define ADDR_TX_CONFIG   4'h4
`define ADDR_RX_STATUS   4'h5
`define ADDR_TX_STATUS   4'h6
`define ADDR_IRQ_STATUS  4'h7
`define ADDR_IRQ_ENABLE  4'h8
`define ADDR_IRQ_CLEAR   4'h9
`define TXCFG_CLEAR_BIT  7
`define TXCFG_COND_BIT   6
`define STAT_OVR_BIT     7
`define SETUP_EN_BIT     0
`define SETUP_FULL_BIT   1
`define TXCFG_RESET      3'h0
`define DEPTH_HALF       3'h4
`define DEPTH_FULL       3'h2
`define IRQ_TX_BIT       0
`define IRQ_OVR_BIT      1
`endif

// ==== dv/serial_fifo_monitor.sv ====
// assertions on the register and irq ports of the fifo control block
// assumes one-cycle strobes and read data in the cycle after a read
`timescale 1ns/10ps
module serial_fifo_monitor (
  // clock and reset
  input wire        clk,
  input wire        reset,
  // register port, receive push and irq
  input wire [3:0]  addr,
  input wire [31:0] wrData,
  input wire        wrStrobe,
  input wire        rdStrobe,
  input wire [31:0] rdData,
  input wire        rxPush,
  input wire        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------
  // properties
  // ----------
  property p_cfgRd;
    rdStrobe && addr == 4'h4 |=> rdData[31:7] == 25'h0 && rdData[5:2] == 4'h0;
  endproperty
  property p_rxStat;
    rdStrobe && addr == 4'h5 |=> rdData[31:8] == 24'h0 &&
      rdData[6:3] == 4'h0 && rdData[2:0] <= 3'h4;
  endproperty
  property p_txStat;
    rdStrobe && addr == 4'h6 |=> rdData[6:3] == 4'h0 && rdData[2:0] <= 3'h4;
  endproperty
  // a push in the gap could set the flag again, so it is excluded
  property p_ovrClr;
    rdStrobe && addr == 4'h0 ##1 !rxPush ##1
      rdStrobe && addr == 4'h5 && !rxPush |=> !rdData[7];
  endproperty
  property p_hold;
    !rdStrobe |=> $stable(rdData);
  endproperty
  property p_irqOff;
    wrStrobe && addr == 4'h8 && wrData[1:0] == 2'h0 |=> !irq;
  endproperty
  property p_unmap;
    rdStrobe && addr > 4'h9 |=> rdData == 32'h0;
  endproperty
  property p_disRst;
    wrStrobe && addr == 4'h1 && !wrData[0] ##2
      rdStrobe && addr == 4'h4 |=> rdData == 32'h0;
  endproperty
  a_cfgRd: assert property (p_cfgRd) else $error("config readback");
  a_rxStat: assert property (p_rxStat) else $error("rx status");
  a_txStat: assert property (p_txStat) else $error("tx level");
  a_ovrClr: assert property (p_ovrClr) else $error("overrun kept");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_irqOff: assert property (p_irqOff) else $error("irq not masked");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_disRst: assert property (p_disRst) else $error("config kept");
  c_ovrClr: cover property (p_ovrClr);
  c_irq: cover property ($rose(irq));
  c_dis: cover property (wrStrobe && addr == 4'h1 && !wrData[0]);
endmodule
bind serial_fifo_threshold_status serial_fifo_monitor mon (
  .clk, .reset, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .rxPush, .irq
);

// ==== dv/testbench.sv ====
// hand-written scenarios for the fifo control and status block
// assumes the register indices of the designer's constants header
`timescale 1ns/10ps
module testbench;
  reg         clk = 1'b0, reset = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0;
  reg         idleEntry = 1'b0, txTake = 1'b0, rxPush = 1'b0;
  reg  [3:0]  addr = 4'h0;
  reg  [7:0]  rxByte = 8'h00;
  reg  [31:0] wrData = 32'h0, got;
  wire [31:0] rdData;
  wire [7:0]  txByte;
  wire        txValid, irq;
  integer     errTotal = 0, nTests = 0, i;
  always #4 clk = ~clk;
  serial_fifo_threshold_status dut (
    .clk       (clk),
    .reset     (reset),
    .addr      (addr),
    .wrData    (wrData),
    .wrStrobe  (wrStrobe),
    .rdStrobe  (rdStrobe),
    .rdData    (rdData),
    .idleEntry (idleEntry),
    .txValid   (txValid),
    .txByte    (txByte),
    .txTake    (txTake),
    .rxPush    (rxPush),
    .rxByte    (rxByte),
    .irq       (irq)
  );
  // ----------
  // bus tasks
  // ----------
  task chk(input [31:0] g, input [31:0] e);
    begin
      nTests = nTests + 1;
      if (g !== e) begin
        errTotal = errTotal + 1;
        $display("Error t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 got = rdData;
    end
  endtask
  // k: 0 receive push, 1 transmit take, 2 idle entry
  task pulse(input [1:0] k, input [7:0] b);
    begin
      @(posedge clk);
      rxByte <= b;
      {idleEntry, txTake, rxPush} <= 3'h1 << k;
      @(posedge clk);
      {idleEntry, txTake, rxPush} <= 3'h0;
    end
  endtask
  // duplex and enable first, clear afterwards
  task setup(input [31:0] m);
    begin
      wr(4'h1, 32'h1);
      wr(4'h3, m);
      wr(4'h4, 32'h80);
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task sReset;
    begin
      rd(4'h5);
      chk(got, 32'h0);
      rd(4'h6);
      chk(got, 32'h0);
      rd(4'hC);
      chk(got, 32'h0);
    end
  endtask
  task sTx;
    begin
      setup(32'h1);
      wr(4'h4, 32'hC3);
      rd(4'h4);
      chk(got, 32'h43);
      for (i = 0; i < 3; i = i + 1)
        wr(4'h0, 32'h11 + i);
      rd(4'h6);
      chk({got[2:0], txValid, txByte}, 12'h711);
      wr(4'h4, 32'hC3);
      rd(4'h6);
      chk({got[2:0], txValid}, 4'h0);
    end
  endtask
  // pops of zero means a clear write instead of shifter takes
  task sThr(input [31:0] m, c, input integer f, p, input e);
    begin
      setup(m);
      wr(4'h4, 32'h80 | c);
      for (i = 0; i < f; i = i + 1)
        wr(4'h0, i);
      wr(4'h9, 32'h3);
      if (p == 0)
        wr(4'h4, 32'h80 | c);
      for (i = 0; i < p; i = i + 1)
        pulse(2'h1, 8'h00);
      rd(4'h7);
      chk({got[0], irq}, {e, e});
    end
  endtask
  task sRx;
    begin
      setup(32'h1);
      for (i = 0; i < 5; i = i + 1) begin
        if (i == 4)
          rd(4'h5);
        if (i == 4)
          chk(got, 32'h4);
        pulse(2'h0, 8'hA0 + i);
      end
      rd(4'h5);
      chk(got, 32'h84);
      rd(4'h0);
      chk(got, 32'hA0);
      rd(4'h5);
      chk(got, 32'h3);
    end
  endtask
  task sIdle(input [31:0] r, e);
    begin
      wr(4'h1, 32'h1);
      wr(4'h2, r);
      wr(4'h4, 32'h43);
      pulse(2'h2, 8'h00);
      wr(4'h1, r);
      rd(4'h4);
      chk(got, e);
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #100000;
    errTotal = errTotal + 1;
    summarize;
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    sReset;
    sTx;
    wr(4'h8, 32'h1);
    sThr(32'h1, 32'h02, 3, 1, 1'b1);
    sThr(32'h3, 32'h02, 1, 1, 1'b1);
    sThr(32'h1, 32'h02, 1, 1, 1'b0);
    sThr(32'h1, 32'h01, 3, 0, 1'b0);
    sThr(32'h1, 32'h41, 3, 0, 1'b1);
    sThr(32'h3, 32'h03, 3, 1, 1'b1);
    wr(4'h8, 32'h0);
    #1;
    chk(irq, 1'b0);
    wr(4'h9, 32'h3);
    sRx;
    sIdle(32'h1, 32'h43);
    sIdle(32'h0, 32'h0);
    summarize;
  end
endmodule
